/* rtl/lfr_pkg.sv */
package lfr_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register indices; byte address is four times the index
    localparam int         NUM_REGS         = 17;
    localparam logic [7:0] IDX_PWR_ALARM_A  = 8'h13;
    localparam logic [7:0] IDX_PWR_ALARM_B  = 8'h14;
    localparam logic [7:0] IDX_PWR_ALARM_C  = 8'h15;
    localparam logic [7:0] IDX_LC_FILTER    = 8'h16;
    localparam logic [7:0] IDX_RT_FILTER    = 8'h17;
    localparam logic [7:0] IDX_THERM_A      = 8'h18;
    localparam logic [7:0] IDX_THERM_B      = 8'h19;
    localparam logic [7:0] IDX_THERM_C      = 8'h1a;
    localparam logic [7:0] IDX_RING_BIAS    = 8'h1b;
    localparam logic [7:0] IDX_OVERHEAD     = 8'h40;
    localparam logic [7:0] IDX_LC_LOW       = 8'h42;
    localparam logic [7:0] IDX_SPACE_AMP    = 8'h45;
    localparam logic [7:0] IDX_SPACE_FREQ   = 8'h46;
    localparam logic [7:0] IDX_MARK_AMP     = 8'h47;
    localparam logic [7:0] IDX_MARK_FREQ    = 8'h48;
    localparam logic [7:0] IDX_S2M_GAIN     = 8'h49;
    localparam logic [7:0] IDX_M2S_GAIN     = 8'h4a;
    localparam logic [7:0] IDX_CTRL         = 8'h50;
    localparam logic [7:0] IDX_STATUS       = 8'h51;

    // Index table in bank slot order
    localparam logic [NUM_REGS-1:0][7:0] SLOT_INDEX = {
        IDX_M2S_GAIN, IDX_S2M_GAIN, IDX_MARK_FREQ, IDX_MARK_AMP, IDX_SPACE_FREQ,
        IDX_SPACE_AMP, IDX_LC_LOW, IDX_OVERHEAD, IDX_RING_BIAS, IDX_THERM_C,
        IDX_THERM_B, IDX_THERM_A, IDX_RT_FILTER, IDX_LC_FILTER, IDX_PWR_ALARM_C,
        IDX_PWR_ALARM_B, IDX_PWR_ALARM_A};

    // Bank slots read by the logic
    localparam int SLOT_OVERHEAD   = 9;
    localparam int SLOT_LC_LOW     = 10;
    localparam int SLOT_SPACE_AMP  = 11;
    localparam int SLOT_SPACE_FREQ = 12;
    localparam int SLOT_MARK_AMP   = 13;
    localparam int SLOT_MARK_FREQ  = 14;
    localparam int SLOT_S2M_GAIN   = 15;
    localparam int SLOT_M2S_GAIN   = 16;

    ////////////////////////////////////////////////////////////////////////////////
    // Control register fields and constants
    localparam int          CTRL_HYST_BIT      = 0;
    localparam int          CTRL_OV_RANGE_BIT  = 4;
    localparam int          CTRL_TONE_BIT      = 6;
    localparam int          CTRL_REFRESH_BIT   = 7;
    localparam logic [15:0] CTRL_RESET         = 16'h0000;
    localparam logic [15:0] BANK_RESET         = 16'h0000;
    localparam logic [15:0] GAIN_UNITY         = 16'h4000;
    localparam int          OV_CODE_W          = 4;
    localparam int          LC_THRESH_W        = 6;
    localparam logic [21:0] ADDR_HIGH_ZERO     = 22'h000000;
    localparam logic [1:0]  RESP_OKAY          = 2'h0;
    localparam logic [1:0]  RESP_SLVERR        = 2'h2;

    ////////////////////////////////////////////////////////////////////////////////
    // Carrier types
    typedef struct packed {
        logic       hit;
        logic [4:0] slot;
    } lfr_decode_t;

    typedef struct packed {
        logic [15:0] amplitude;
        logic [15:0] frequency;
        logic [15:0] gain;
        logic        load;
    } lfr_osc_load_t;

    typedef struct packed {
        logic [OV_CODE_W-1:0]   overhead_voltage_code;
        logic                   overhead_range_select;
        logic                   hysteresis_enable;
        logic [LC_THRESH_W-1:0] loop_closure_release_thresh;
    } lfr_line_cfg_t;

endpackage

/* rtl/lfr_indirect_bank.sv */
module lfr_indirect_bank (
    // Clock and reset
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    // AXI4-Lite write address and data
    input  wire logic [31:0]              s_axi_awaddr,
    input  wire logic [2:0]               s_axi_awprot,
    input  wire logic                     s_axi_awvalid,
    output logic                          s_axi_awready,
    input  wire logic [31:0]              s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output logic                          s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                    s_axi_bresp,
    output logic                          s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    // AXI4-Lite read
    input  wire logic [31:0]              s_axi_araddr,
    input  wire logic [2:0]               s_axi_arprot,
    input  wire logic                     s_axi_arvalid,
    output logic                          s_axi_arready,
    output logic [31:0]                   s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    output logic                          s_axi_rvalid,
    input  wire logic                     s_axi_rready,
    // Oscillator one reload
    input  wire logic                     oscillator_one_active_timer,
    input  wire logic                     tone_bit,
    input  wire logic [15:0]              normal_amplitude_coef,
    input  wire logic [15:0]              normal_frequency_coef,
    output lfr_pkg::lfr_osc_load_t        osc_load,
    // Line supervision
    input  wire logic [lfr_pkg::LC_THRESH_W-1:0] loop_closure_upper_thresh,
    output lfr_pkg::lfr_line_cfg_t        line_cfg
);

    ////////////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [lfr_pkg::NUM_REGS-1:0][15:0] bank;
        logic [15:0]                        ctrl;
        logic                               aw_full;
        logic [31:0]                        aw_addr;
        logic                               w_full;
        logic [31:0]                        w_data;
        logic [3:0]                         w_strb;
        logic                               bvalid;
        logic [1:0]                         bresp;
        logic                               rvalid;
        logic [1:0]                         rresp;
        logic [31:0]                        rdata;
        logic                               bit_known;
        logic                               last_bit;
        lfr_pkg::lfr_osc_load_t             osc;
        lfr_pkg::lfr_line_cfg_t             line;
    } lfr_state_t;

    lfr_state_t state_reg;
    lfr_state_t state_next;

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode into a bank slot
    function automatic lfr_pkg::lfr_decode_t decode_slot(input logic [31:0] addr);
        lfr_pkg::lfr_decode_t d;
        d.hit  = 1'b0;
        d.slot = 5'h00;
        for (int i = 0; i < lfr_pkg::NUM_REGS; i++) begin
            if (addr[31:10] == lfr_pkg::ADDR_HIGH_ZERO &&
                addr[9:2] == lfr_pkg::SLOT_INDEX[i]) begin
                d.hit  = 1'b1;
                d.slot = 5'(i);
            end
        end
        return d;
    endfunction

    // Apply byte strobes to a 16-bit word
    function automatic logic [15:0] merge16(input logic [15:0] old_val,
                                            input logic [31:0] data,
                                            input logic [3:0]  strb);
        logic [15:0] v;
        v = old_val;
        if (strb[0]) begin
            v[7:0] = data[7:0];
        end
        if (strb[1]) begin
            v[15:8] = data[15:8];
        end
        return v;
    endfunction

    // Match a byte address against one own register index
    function automatic logic is_index(input logic [31:0] addr,
                                      input logic [7:0]  idx);
        logic match;
        match = (addr[31:10] == lfr_pkg::ADDR_HIGH_ZERO) && (addr[9:2] == idx);
        return match;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Handshake outputs
    assign s_axi_awready = !state_reg.aw_full && !state_reg.bvalid;
    assign s_axi_wready  = !state_reg.w_full && !state_reg.bvalid;
    assign s_axi_arready = !state_reg.rvalid;

    // Registered outputs
    assign s_axi_bvalid = state_reg.bvalid;
    assign s_axi_bresp  = state_reg.bresp;
    assign s_axi_rvalid = state_reg.rvalid;
    assign s_axi_rresp  = state_reg.rresp;
    assign s_axi_rdata  = state_reg.rdata;
    assign osc_load     = state_reg.osc;
    assign line_cfg     = state_reg.line;

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        lfr_pkg::lfr_decode_t wdec;
        lfr_pkg::lfr_decode_t rdec;
        logic                 tone_mode;
        logic [15:0]          amp;
        logic [15:0]          freq;
        logic [15:0]          gain;
        logic                 write_fire;
        logic                 wr_ctrl;
        logic                 wr_status;
        logic                 rd_ctrl;
        logic                 rd_status;
        wdec       = decode_slot(state_reg.aw_addr);
        rdec       = decode_slot(s_axi_araddr);
        write_fire = state_reg.aw_full && state_reg.w_full && !state_reg.bvalid;
        wr_ctrl    = is_index(state_reg.aw_addr, lfr_pkg::IDX_CTRL);
        wr_status  = is_index(state_reg.aw_addr, lfr_pkg::IDX_STATUS);
        rd_ctrl    = is_index(s_axi_araddr, lfr_pkg::IDX_CTRL);
        rd_status  = is_index(s_axi_araddr, lfr_pkg::IDX_STATUS);
        tone_mode  = 1'b0;
        amp        = 16'h0000;
        freq       = 16'h0000;
        gain       = lfr_pkg::GAIN_UNITY;
        state_next = state_reg;

        // Write address and data capture, either order
        if (s_axi_awvalid && s_axi_awready) begin
            state_next.aw_full = 1'b1;
            state_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            state_next.w_full = 1'b1;
            state_next.w_data = s_axi_wdata;
            state_next.w_strb = s_axi_wstrb;
        end

        // Perform write once both halves are held
        if (write_fire) begin
            state_next.aw_full = 1'b0;
            state_next.w_full  = 1'b0;
            state_next.bvalid  = 1'b1;
            state_next.bresp   = lfr_pkg::RESP_OKAY;
            if (wdec.hit) begin
                state_next.bank[wdec.slot] = merge16(state_reg.bank[wdec.slot],
                                                     state_reg.w_data, state_reg.w_strb);
            end else if (wr_ctrl) begin
                state_next.ctrl = merge16(state_reg.ctrl, state_reg.w_data,
                                          state_reg.w_strb);
            end else if (!wr_status) begin
                // Unmapped write dropped, error reported
                state_next.bresp = lfr_pkg::RESP_SLVERR;
            end
        end
        if (state_reg.bvalid && s_axi_bready) begin
            state_next.bvalid = 1'b0;
        end

        // Read decode
        if (s_axi_arvalid && s_axi_arready) begin
            state_next.rvalid = 1'b1;
            state_next.rresp  = lfr_pkg::RESP_OKAY;
            state_next.rdata  = 32'h00000000;
            if (rdec.hit) begin
                state_next.rdata[15:0] = state_reg.bank[rdec.slot];
            end else if (rd_ctrl) begin
                state_next.rdata[15:0] = state_reg.ctrl;
            end else if (rd_status) begin
                // Last loaded oscillator values
                state_next.rdata = {state_reg.osc.frequency, state_reg.osc.amplitude};
            end else begin
                // Unmapped read returns zero with error
                state_next.rresp = lfr_pkg::RESP_SLVERR;
            end
        end else if (state_reg.rvalid && s_axi_rready) begin
            state_next.rvalid = 1'b0;
        end

        // Enhanced mode needs both enables
        tone_mode = state_reg.ctrl[lfr_pkg::CTRL_TONE_BIT] &&
                    state_reg.ctrl[lfr_pkg::CTRL_REFRESH_BIT];

        // Coefficient selection at timer expiry
        if (tone_mode) begin
            if (tone_bit) begin
                amp  = state_reg.bank[lfr_pkg::SLOT_MARK_AMP];
                freq = state_reg.bank[lfr_pkg::SLOT_MARK_FREQ];
            end else begin
                amp  = state_reg.bank[lfr_pkg::SLOT_SPACE_AMP];
                freq = state_reg.bank[lfr_pkg::SLOT_SPACE_FREQ];
            end
            if (state_reg.bit_known && tone_bit && !state_reg.last_bit) begin
                gain = state_reg.bank[lfr_pkg::SLOT_S2M_GAIN];
            end else if (state_reg.bit_known && !tone_bit && state_reg.last_bit) begin
                gain = state_reg.bank[lfr_pkg::SLOT_M2S_GAIN];
            end
        end else begin
            amp  = normal_amplitude_coef;
            freq = normal_frequency_coef;
        end

        // Reload oscillator one
        state_next.osc.load = 1'b0;
        if (oscillator_one_active_timer) begin
            state_next.osc.load      = 1'b1;
            state_next.osc.amplitude = amp;
            state_next.osc.frequency = freq;
            state_next.osc.gain      = gain;
            state_next.bit_known     = tone_mode;
            state_next.last_bit      = tone_bit;
        end

        // Line supervision settings
        state_next.line.overhead_voltage_code =
            state_reg.bank[lfr_pkg::SLOT_OVERHEAD][lfr_pkg::OV_CODE_W-1:0];
        state_next.line.overhead_range_select =
            state_reg.ctrl[lfr_pkg::CTRL_OV_RANGE_BIT];
        state_next.line.hysteresis_enable = state_reg.ctrl[lfr_pkg::CTRL_HYST_BIT];
        if (state_reg.ctrl[lfr_pkg::CTRL_HYST_BIT]) begin
            state_next.line.loop_closure_release_thresh =
                state_reg.bank[lfr_pkg::SLOT_LC_LOW][lfr_pkg::LC_THRESH_W-1:0];
        end else begin
            state_next.line.loop_closure_release_thresh = loop_closure_upper_thresh;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg          <= '0;
            state_reg.bank     <= {lfr_pkg::NUM_REGS{lfr_pkg::BANK_RESET}};
            state_reg.ctrl     <= lfr_pkg::CTRL_RESET;
            state_reg.osc.gain <= lfr_pkg::GAIN_UNITY;
        end else begin
            state_reg <= state_next;
        end
    end

endmodule

/* verification/lfr_bank_asserts.sv */
module lfr_bank_asserts (
    // Clock and reset
    input wire logic             aclk,
    input wire logic             aresetn,
    // Register bus handshakes
    input wire logic             s_axi_awvalid,
    input wire logic             s_axi_awready,
    input wire logic             s_axi_wvalid,
    input wire logic             s_axi_wready,
    input wire logic [1:0]       s_axi_bresp,
    input wire logic             s_axi_bvalid,
    input wire logic             s_axi_bready,
    input wire logic             s_axi_arvalid,
    input wire logic             s_axi_arready,
    input wire logic [31:0]      s_axi_rdata,
    input wire logic             s_axi_rvalid,
    input wire logic             s_axi_rready,
    // Oscillator reload
    input wire logic             oscillator_one_active_timer,
    input wire lfr_pkg::lfr_osc_load_t osc_load
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    ////////////////////////////////////////////////////////////////////////////////
    // Reload pulse and held coefficients
    chk_load_follows: assert property (oscillator_one_active_timer |=> osc_load.load)
        else $error("reload pulse missing after expiry");
    chk_no_stray_load: assert property (!oscillator_one_active_timer |=> !osc_load.load)
        else $error("reload pulse without expiry");
    chk_coef_hold: assert property (!oscillator_one_active_timer |=>
        $stable(osc_load.amplitude) && $stable(osc_load.frequency) && $stable(osc_load.gain))
        else $error("oscillator values moved without expiry");

    ////////////////////////////////////////////////////////////////////////////////
    // Register bus answers and refusals
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    chk_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    chk_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    chk_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    chk_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");

    // Main scenarios reached
    cov_reload: cover property (osc_load.load);
    cov_write: cover property (s_axi_bvalid && s_axi_bready);
    cov_read: cover property (s_axi_rvalid && s_axi_rready);
    cov_gain: cover property (osc_load.load && osc_load.gain != lfr_pkg::GAIN_UNITY);
endmodule

bind lfr_indirect_bank lfr_bank_asserts u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .oscillator_one_active_timer,
    .osc_load);

/* verification/testbench.sv */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////////////
    // Drives and observed outputs
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, data;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, resp;
    logic        timer = 1'b0, tone = 1'b0;
    logic [15:0] namp = 16'h1111, nfreq = 16'h2222;
    logic [5:0]  upper = 6'h2a;
    int          mismatches = 0, tests_run = 0;
    lfr_pkg::lfr_osc_load_t osc_load;
    lfr_pkg::lfr_line_cfg_t line_cfg;

    always #2 aclk = ~aclk;

    lfr_indirect_bank uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .oscillator_one_active_timer(timer),
        .tone_bit(tone), .normal_amplitude_coef(namp), .normal_frequency_coef(nfreq),
        .osc_load(osc_load), .loop_closure_upper_thresh(upper), .line_cfg(line_cfg));

    ////////////////////////////////////////////////////////////////////////////////
    // Comparison, bus and expiry tasks
    function automatic logic [15:0] pat(input logic [7:0] i);
        return {i, ~i};
    endfunction

    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [15:0] val, input logic [1:0] er);
        logic a, w, b;
        @(posedge aclk);
        awaddr  <= {22'h000000, idx, 2'b00};
        wdata   <= {16'h0000, val};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(negedge aclk);
            a = awvalid && awready;
            w = wvalid && wready;
            b = bvalid;
            resp = bresp;
            @(posedge aclk);
            if (a) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
        end while (!b);
        bready <= 1'b0;
        compare({30'h0, resp}, {30'h0, er});
    endtask

    task automatic rd(input logic [7:0] idx, input logic [31:0] ed, input logic [1:0] er);
        logic a, r;
        @(posedge aclk);
        araddr  <= {22'h000000, idx, 2'b00};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(negedge aclk);
            a = arvalid && arready;
            r = rvalid;
            data = rdata;
            resp = rresp;
            @(posedge aclk);
            if (a) arvalid <= 1'b0;
        end while (!r);
        rready <= 1'b0;
        compare(data, ed);
        compare({30'h0, resp}, {30'h0, er});
    endtask

    task automatic expire(input logic t, input logic [15:0] amp, frq, gain);
        @(posedge aclk);
        timer <= 1'b1;
        tone  <= t;
        @(posedge aclk);
        timer <= 1'b0;
        @(negedge aclk);
        compare({osc_load.amplitude, osc_load.frequency}, {amp, frq});
        compare({osc_load.gain, 15'h0000, osc_load.load}, {gain, 16'h0001});
    endtask

    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Test sequence
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        compare({osc_load.gain, osc_load.amplitude}, {lfr_pkg::GAIN_UNITY, 16'h0000});
        for (int i = 0; i < lfr_pkg::NUM_REGS; i++) begin
            wr(lfr_pkg::SLOT_INDEX[i], pat(lfr_pkg::SLOT_INDEX[i]), 2'h0);
            rd(lfr_pkg::SLOT_INDEX[i], {16'h0000, pat(lfr_pkg::SLOT_INDEX[i])}, 2'h0);
        end
        wr(8'h30, 16'hbeef, lfr_pkg::RESP_SLVERR);
        rd(8'h30, 32'h0, lfr_pkg::RESP_SLVERR);
        wr(lfr_pkg::IDX_STATUS, 16'h1234, lfr_pkg::RESP_OKAY);
        wr(lfr_pkg::IDX_CTRL, 16'h0040, 2'h0);
        expire(1'b1, 16'h1111, 16'h2222, lfr_pkg::GAIN_UNITY);
        wr(lfr_pkg::IDX_CTRL, 16'h0080, 2'h0);
        expire(1'b0, 16'h1111, 16'h2222, lfr_pkg::GAIN_UNITY);
        wr(lfr_pkg::IDX_CTRL, 16'h0000, 2'h0);
        namp  <= 16'h3333;
        nfreq <= 16'h4444;
        expire(1'b1, 16'h3333, 16'h4444, lfr_pkg::GAIN_UNITY);
        wr(lfr_pkg::IDX_CTRL, 16'h00c0, 2'h0);
        expire(1'b1, pat(8'h47), pat(8'h48), lfr_pkg::GAIN_UNITY);
        expire(1'b0, pat(8'h45), pat(8'h46), pat(8'h4a));
        expire(1'b1, pat(8'h47), pat(8'h48), pat(8'h49));
        expire(1'b1, pat(8'h47), pat(8'h48), lfr_pkg::GAIN_UNITY);
        rd(lfr_pkg::IDX_STATUS, {pat(8'h48), pat(8'h47)}, 2'h0);
        wr(lfr_pkg::IDX_RING_BIAS, 16'h0000, 2'h0);
        wr(lfr_pkg::IDX_OVERHEAD, 16'h0009, 2'h0);
        wr(lfr_pkg::IDX_LC_LOW, 16'h0015, 2'h0);
        wr(lfr_pkg::IDX_CTRL, 16'h0011, 2'h0);
        repeat (2) @(negedge aclk);
        compare({20'h0, line_cfg}, {20'h0, 4'h9, 1'b1, 1'b1, 6'h15});
        wr(lfr_pkg::IDX_CTRL, 16'h0000, 2'h0);
        wr(lfr_pkg::IDX_OVERHEAD, 16'h0006, 2'h0);
        upper <= 6'h1c;
        repeat (2) @(negedge aclk);
        compare({20'h0, line_cfg}, {20'h0, 4'h6, 1'b0, 1'b0, 6'h1c});
        final_report();
    end

    // Hang guard
    initial begin
        #40000;
        mismatches++;
        final_report();
    end
endmodule
